// file: dlt_regs.vh
// register offsets, field positions and reset values for the load trigger bank
`ifndef DLT_REGS_VH
`define DLT_REGS_VH
`define DLT_ADDR_SOFT_LOAD   8'h45
`define DLT_ADDR_STAGE0      8'h46
`define DLT_ADDR_STAGE1      8'h49
`define DLT_RST_SOFT_LOAD    8'h00
`define DLT_RST_CODE         16'h0000
`define DLT_BIT_LOAD_CH0     0
`define DLT_BIT_LOAD_CH1     1
`define DLT_CODE_MSB         23
`define DLT_CODE_LSB         8
`endif

// file: dlt_load_trigger.v
// staging registers, software load trigger and active code transfer
//
// Overview of operation
// [RULE1] writing one to bit one loads channel one
// [RULE2] writing one to bit zero loads channel zero
// [RULE3] load bits self clear, never stored
// [RULE4] software load equals a strobe low pulse
// [RULE5] trigger at 0x45, reset zero, [7:2] reserved
// [RULE6] staging at 0x46 and 0x49, reset zero
// [RULE7] code in [23:8], low byte reads zero
// [RULE8] strobe, software bit or auto transfer loads
// [RULE9] logic held in reset until supplies good
// [RULE10] mask bit one ignores strobe for channel
// [RULE11] active register code in [23:8]
// [RULE12] coinciding triggers give one single transfer
`timescale 1ns/1ps
`default_nettype none
`include "dlt_regs.vh"

module dlt_load_trigger
(
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  input  wire        i_supply_good,
  input  wire        i_wr_en,
  input  wire [7:0]  i_addr,
  input  wire [23:0] i_wr_data,
  input  wire        i_output_update_strobe_n,
  input  wire        i_strobe_mask_chan0,
  input  wire        i_strobe_mask_chan1,
  input  wire        i_auto_transfer,
  output reg  [23:0] o_rd_data,
  output reg  [23:0] o_channel0_active_code,
  output reg  [23:0] o_channel1_active_code,
  output reg         o_load_pulse_chan0,
  output reg         o_load_pulse_chan1
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release, gated by supply monitor
  wire       rst_in_n;
  reg  [1:0] rst_sync_q;
  wire       rst_n;

  assign rst_in_n = i_reset_n & i_supply_good; // RULE9

  always @(posedge i_sys_clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // strobe pin sync: three stages, falling edge once stages two and three agree
  reg  [2:0] strb_sync_q;
  reg        strb_stable_q;
  wire       strb_fall;

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strb_sync_q   <= 3'h7;
      strb_stable_q <= 1'b1;
    end
    else
    begin
      strb_sync_q <= {strb_sync_q[1:0], i_output_update_strobe_n};
      if (strb_sync_q[1] == strb_sync_q[2])
        strb_stable_q <= strb_sync_q[2];
    end
  end
  assign strb_fall = strb_stable_q & (strb_sync_q[1] == strb_sync_q[2]) & ~strb_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // auto transfer input sync (level)
  reg [2:0] auto_sync_q;
  reg       auto_q;

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auto_sync_q <= 3'h0;
      auto_q      <= 1'b0;
    end
    else
    begin
      auto_sync_q <= {auto_sync_q[1:0], i_auto_transfer};
      if (auto_sync_q[1] == auto_sync_q[2])
        auto_q <= auto_sync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and transfers
  wire        wr_soft;
  wire        wr_stage0;
  wire        wr_stage1;
  wire        load0;
  wire        load1;
  reg  [15:0] stage0_q;
  reg  [15:0] stage1_q;
  reg  [15:0] active0_q;
  reg  [15:0] active1_q;

  assign wr_soft   = i_wr_en & (i_addr == `DLT_ADDR_SOFT_LOAD);    // RULE5
  assign wr_stage0 = i_wr_en & (i_addr == `DLT_ADDR_STAGE0);       // RULE6
  assign wr_stage1 = i_wr_en & (i_addr == `DLT_ADDR_STAGE1);       // RULE6

  ////////////////////////////////////////////////////////////////////////////
  // trigger terms, one per source and channel
  wire        soft_ld0;
  wire        soft_ld1;
  wire        strb_ld0;
  wire        strb_ld1;
  wire        auto_ld0;
  wire        auto_ld1;

  assign soft_ld0 = wr_soft & i_wr_data[`DLT_BIT_LOAD_CH0];        // RULE2 RULE4
  assign soft_ld1 = wr_soft & i_wr_data[`DLT_BIT_LOAD_CH1];        // RULE1 RULE4
  assign strb_ld0 = strb_fall & ~i_strobe_mask_chan0;              // RULE10
  assign strb_ld1 = strb_fall & ~i_strobe_mask_chan1;              // RULE10
  assign auto_ld0 = auto_q & wr_stage0;                            // RULE8
  assign auto_ld1 = auto_q & wr_stage1;                            // RULE8

  // one OR, so a coincident strobe and soft bit make one transfer
  assign load0 = soft_ld0 | strb_ld0 | auto_ld0;                   // RULE12
  assign load1 = soft_ld1 | strb_ld1 | auto_ld1;                   // RULE12

  ////////////////////////////////////////////////////////////////////////////
  // staging codes: only [23:8] of a write is kept, the low byte is reserved
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // held at zero until both supplies are good
      stage0_q <= `DLT_RST_CODE;                                   // RULE6 RULE9
    end
    else
    begin
      // writes to other addresses leave the code alone
      if (wr_stage0)
      begin
        stage0_q <= i_wr_data[`DLT_CODE_MSB:`DLT_CODE_LSB];        // RULE7
      end
    end
  end

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= `DLT_RST_CODE;                                   // RULE6
    end
    else
    begin
      // writes to other addresses leave the code alone
      if (wr_stage1)
      begin
        stage1_q <= i_wr_data[`DLT_CODE_MSB:`DLT_CODE_LSB];        // RULE7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next active codes; auto transfer takes the code written this cycle,
  // so a staging write under auto transfer never moves the stale code
  reg  [15:0] active0_d;
  reg  [15:0] active1_d;

  always @*
  begin
    active0_d = active0_q;
    // without a trigger the code simply holds
    if (load0)
    begin
      if (auto_ld0)
      begin
        active0_d = i_wr_data[`DLT_CODE_MSB:`DLT_CODE_LSB];        // RULE8
      end
      else
      begin
        active0_d = stage0_q;                                      // RULE4
      end
    end
  end

  always @*
  begin
    active1_d = active1_q;
    // without a trigger the code simply holds
    if (load1)
    begin
      if (auto_ld1)
      begin
        active1_d = i_wr_data[`DLT_CODE_MSB:`DLT_CODE_LSB];        // RULE8
      end
      else
      begin
        active1_d = stage1_q;                                      // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active codes stand until the next transfer
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active0_q <= `DLT_RST_CODE;
    end
    else
    begin
      active0_q <= active0_d;                                      // RULE8
    end
  end

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active1_q <= `DLT_RST_CODE;
    end
    else
    begin
      active1_q <= active1_d;                                      // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load pulses: one cycle, the cycle after a transfer; they show a
  // transfer even when the new code equals the old one
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_load_pulse_chan0 <= 1'b0;
    end
    else
    begin
      o_load_pulse_chan0 <= load0;                                 // RULE12
    end
  end

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_load_pulse_chan1 <= 1'b0;
    end
    else
    begin
      o_load_pulse_chan1 <= load1;                                 // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active outputs: reserved low byte is always zero
  always @*
  begin
    o_channel0_active_code = {active0_q, 8'h00};                   // RULE11
  end

  always @*
  begin
    o_channel1_active_code = {active1_q, 8'h00};                   // RULE11
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback: load bits are never stored, so they read zero;
  // an unmapped address reads zero as well
  always @*
  begin
    case (i_addr)
      `DLT_ADDR_SOFT_LOAD:
      begin
        o_rd_data = {16'h0000, `DLT_RST_SOFT_LOAD};                // RULE3 RULE5
      end
      // code in [23:8], reserved low byte reads zero
      `DLT_ADDR_STAGE0:
      begin
        o_rd_data = {stage0_q, 8'h00};                             // RULE7
      end
      `DLT_ADDR_STAGE1:
      begin
        o_rd_data = {stage1_q, 8'h00};                             // RULE7
      end
      default:
      begin
        o_rd_data = 24'h000000;
      end
    endcase
  end

endmodule // dlt_load_trigger
`default_nettype wire

// file: dlt_host_model.sv
// host model driving register writes and readback
`timescale 1ns/1ps
`default_nettype none
module dlt_host_model
(
  input  wire logic        i_clk,
  input  wire logic [23:0] i_rd_data,
  output var  logic        o_wr_en = 1'b0,
  output var  logic [7:0]  o_addr = 8'h00,
  output var  logic [23:0] o_wr_data = 24'h000000
);
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
  endtask
  // sample at the falling edge so the readback has settled
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge i_clk);
    o_addr <= a;
    @(negedge i_clk);
    d = i_rd_data;
  endtask
endmodule // dlt_host_model
`default_nettype wire

// file: dlt_load_trigger_sva.sv
// port assertions for the load trigger bank
`timescale 1ns/1ps
`default_nettype none
module dlt_chk
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_supply_good,
  input wire logic        i_wr_en,
  input wire logic [7:0]  i_addr,
  input wire logic [23:0] i_wr_data,
  input wire logic [23:0] o_rd_data,
  input wire logic [23:0] o_channel0_active_code,
  input wire logic [23:0] o_channel1_active_code,
  input wire logic        o_load_pulse_chan0,
  input wire logic        o_load_pulse_chan1
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  property p_ld0;
    i_supply_good && i_wr_en && i_addr == 8'h45 && i_wr_data[0] |=> o_load_pulse_chan0;
  endproperty
  a_ld0: assert property (p_ld0) else $error("no chan0 load");
  property p_ld1;
    i_supply_good && i_wr_en && i_addr == 8'h45 && i_wr_data[1] |=> o_load_pulse_chan1;
  endproperty
  a_ld1: assert property (p_ld1) else $error("no chan1 load");
  property p_rd; i_addr == 8'h45 |-> o_rd_data == 24'h000000; endproperty
  a_rd: assert property (p_rd) else $error("trigger reads set");
  property p_sup; !i_supply_good |=> o_channel0_active_code == 24'h000000; endproperty
  a_sup: assert property (p_sup) else $error("not held in reset");
  property p_one; $rose(o_load_pulse_chan0) && !i_wr_en |=> !o_load_pulse_chan0; endproperty
  a_one: assert property (p_one) else $error("double transfer");
  property p_low;
    o_channel0_active_code[7:0] == 8'h00 && o_channel1_active_code[7:0] == 8'h00;
  endproperty
  a_low: assert property (p_low) else $error("reserved active bits set");
endmodule // dlt_chk
bind dlt_load_trigger dlt_chk u_chk (.*);
`default_nettype wire

// file: test_dac_input_load_trigger.sv
// self-checking bench for the load trigger bank
`timescale 1ns/1ps
`default_nettype none
module test_dac_input_load_trigger;
  logic        clk = 1'b0, rst_n = 1'b0, sup = 1'b1, sn = 1'b1, m0 = 1'b0, m1 = 1'b0;
  logic        au = 1'b0;
  logic        we, p0, p1;
  logic [7:0]  ad;
  logic [23:0] wd, rd, a0, a1, v;
  int          errors = 0, n_tests = 0;
  initial forever #20 clk = ~clk;
  dlt_host_model u_h (.i_clk(clk), .i_rd_data(rd), .o_wr_en(we), .o_addr(ad), .o_wr_data(wd));
  dlt_load_trigger dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_supply_good(sup),
    .i_wr_en(we), .i_addr(ad), .i_wr_data(wd), .i_output_update_strobe_n(sn),
    .i_strobe_mask_chan0(m0), .i_strobe_mask_chan1(m1), .i_auto_transfer(au),
    .o_rd_data(rd), .o_channel0_active_code(a0), .o_channel1_active_code(a1),
    .o_load_pulse_chan0(p0), .o_load_pulse_chan1(p1));
  ////////////////////
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkp(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: pulse %b expected %b", $time, g, e);
    end
  endtask
  task automatic strobe(input logic k0, input logic k1);
    @(posedge clk);
    m0 <= k0;
    m1 <= k1;
    sn <= 1'b0;
    repeat (3) @(posedge clk);
    sn <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_soft;
    u_h.wr(8'h46, 24'h1234FF);
    u_h.wr(8'h49, 24'hABCD00);
    u_h.wr(8'h45, 24'h0000FC);
    @(negedge clk);
    chkp(p0, 1'b0);
    chkp(p1, 1'b0);
    u_h.wr(8'h45, 24'h000002);
    @(negedge clk);
    chkp(p1, 1'b1);
    chkp(p0, 1'b0);
    u_h.rd(8'h46, v);
    chk(v, 24'h123400);
    chk(a0, 24'h000000);
    chk(a1, 24'hABCD00);
    u_h.wr(8'h45, 24'h000001);
    u_h.rd(8'h45, v);
    chk(v, 24'h000000);
    chk(a0, 24'h123400);
  endtask
  task automatic t_hw;
    u_h.wr(8'h49, 24'h777700);
    u_h.wr(8'h46, 24'h555500);
    strobe(1'b1, 1'b0);
    chk(a0, 24'h123400);
    chk(a1, 24'h777700);
    strobe(1'b0, 1'b1);
    chk(a0, 24'h555500);
    chk(a1, 24'h777700);
  endtask
  task automatic t_auto;
    @(posedge clk);
    au <= 1'b1;
    repeat (5) @(posedge clk);
    u_h.wr(8'h46, 24'h9ABC00);
    @(negedge clk);
    chkp(p0, 1'b1);
    chk(a0, 24'h9ABC00);
    @(posedge clk);
    au <= 1'b0;
    repeat (5) @(posedge clk);
    u_h.wr(8'h49, 24'h111100);
    u_h.rd(8'h49, v);
    chk(a1, 24'h777700);
  endtask
  task automatic t_sup;
    @(posedge clk);
    sup <= 1'b0;
    repeat (2) @(posedge clk);
    sup <= 1'b1;
    u_h.rd(8'h46, v);
    chk(v, 24'h000000);
    chk(a0, 24'h000000);
    chk(a1, 24'h000000);
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_soft();
    t_hw();
    t_auto();
    t_sup();
    test_done();
  end
  initial
  begin
    #40000;
    errors++;
    test_done();
  end
endmodule // test_dac_input_load_trigger
`default_nettype wire
